// *** shared/ura_pkg.sv ***
// register map, access-mode codes and reset values for the register access
// decode of one channel; assumes an 8-bit host bus with a 3-bit offset
`default_nettype none

package ura_pkg;

    // offsets of the ordinary channel registers
    localparam logic [2:0] OFS_DATA       = 3'h0;
    localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
    localparam logic [2:0] OFS_FIFO_CTRL  = 3'h2;
    localparam logic [2:0] OFS_LINE_CTRL  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT  = 3'h5;
    localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH    = 3'h7;

    // offsets of the special registers
    localparam logic [2:0] OFS_DIV_LOW    = 3'h0;
    localparam logic [2:0] OFS_DIV_HIGH   = 3'h1;
    localparam logic [2:0] OFS_FEATURE    = 3'h2;
    localparam logic [2:0] OFS_RESUME_ONE = 3'h4;
    localparam logic [2:0] OFS_RESUME_TWO = 3'h5;
    localparam logic [2:0] OFS_PAUSE_ONE  = 3'h6;
    localparam logic [2:0] OFS_PAUSE_TWO  = 3'h7;
    localparam logic [2:0] OFS_FLOW_THR   = 3'h6;
    localparam logic [2:0] OFS_TRIG_LVL   = 3'h7;
    localparam logic [2:0] OFS_FIFO_RDY   = 3'h7;

    // line control values that open the special maps
    localparam logic [7:0] LCR_DIVISOR    = 8'h80;
    localparam logic [7:0] LCR_FEATURE    = 8'hBF;
    localparam logic [7:0] LCR_PLAIN      = 8'h00;
    localparam int         LCR_DIV_BIT    = 7;

    // field positions
    localparam int         EFR_ENH_BIT    = 4;
    localparam int         MCR_EXT_BIT    = 6;
    localparam int         MCR_RDY_OFF_BIT = 4;
    localparam int         MCR_PRESC_BIT  = 7;

    // bits that only change while enhanced functions are enabled
    localparam logic [7:0] ENH_IER_MASK   = 8'hF0;
    localparam logic [7:0] ENH_FCR_MASK   = 8'h30;
    localparam logic [7:0] ENH_MCR_MASK   = 8'hE0;

    localparam logic [7:0] RST_BYTE       = 8'h00;

    typedef enum logic [1:0] {
        URA_MODE_NORMAL  = 2'b00,
        URA_MODE_DIVISOR = 2'b01,
        URA_MODE_FEATURE = 2'b11
    } ura_mode_type;

endpackage

`default_nettype wire

// *** hw/ura_regs.sv ***
// register bank and access-mode decode for one channel of a quad UART
// assumes host strobes are synchronous to ref_clk_in, one access per cycle;
// serial, fifo and interrupt logic sit outside and feed the status inputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - With line control at 80h, offsets 00h and 01h reach the divisor low and high bytes.
// - With line control at BFh, offset 02h reaches the enhanced feature register.
// - With line control at BFh, offset 06h is pause char one and 04h resume char one.
// - With line control at BFh, offset 07h is pause char two and 05h resume char two.
// - Line control stays at offset 03h in every mode and reads back its value.
// - Offset 06h reaches flow threshold only with line control 00h, feature bit 4 and modem bit 6.
// - Under the same enables offset 07h writes the fifo trigger levels register; reads reach it only with modem bit 4 set.
// - Outside line control BFh, a read of 07h returns fifo-ready status while modem bit 6 is set and bit 4 is clear.
// - Modem control bit 7 selects baud prescale divide-by-4 when set, divide-by-1 when clear.
// - Feature bit 4 write-enables int enable 7:4, fifo control 5:4 and modem control 7:5.
// - Flow threshold holds halt and resume levels as 4-bit nibbles in steps of four bytes.
module ura_regs
    import ura_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        cs_n_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic [7:0]  int_ident_in,
    input  wire logic [7:0]  line_status_in,
    input  wire logic [7:0]  modem_status_in,
    input  wire logic [7:0]  fifo_ready_in,
    output logic      [7:0]  rdata_out,
    output logic             data_oe_n_out,
    output logic             tx_write_out,
    output logic      [7:0]  tx_data_out,
    output logic             rx_read_out,
    output logic      [15:0] divisor_out,
    output logic      [7:0]  feature_out,
    output logic      [7:0]  line_control_out,
    output logic      [7:0]  modem_control_out,
    output logic      [7:0]  int_enable_out,
    output logic      [7:0]  fifo_control_out,
    output logic      [7:0]  resume_one_out,
    output logic      [7:0]  resume_two_out,
    output logic      [7:0]  pause_one_out,
    output logic      [7:0]  pause_two_out,
    output logic      [7:0]  flow_threshold_out,
    output logic      [7:0]  trigger_levels_out,
    output logic             prescale_div4_out
);

    // protected bits keep their old value unless enhanced functions are on
    function automatic logic [7:0] ura_guard(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] mask,
                                             input logic       enh);
        ura_guard = enh ? new_v : ((new_v & ~mask) | (old_v & mask));
    endfunction

    logic [7:0]   div_low_q;
    logic [7:0]   div_high_q;
    logic [7:0]   feature_q;
    logic [7:0]   line_ctrl_q;
    logic [7:0]   modem_ctrl_q;
    logic [7:0]   int_en_q;
    logic [7:0]   fifo_ctrl_q;
    logic [7:0]   resume_one_q;
    logic [7:0]   resume_two_q;
    logic [7:0]   pause_one_q;
    logic [7:0]   pause_two_q;
    logic [7:0]   flow_thr_q;
    logic [7:0]   trig_lvl_q;
    logic [7:0]   scratch_q;
    logic [7:0]   rdata_q;
    logic [7:0]   rdata_d;
    logic         oe_n_q;
    logic         tx_wr_q;
    logic [7:0]   tx_data_q;
    logic         rx_rd_q;

    ura_mode_type mode;
    logic         feat_map;
    logic         div_map;
    logic         norm_map;

    wire wr_acc  = ~cs_n_in & wr_in;
    wire rd_acc  = ~cs_n_in & rd_in;
    wire enh_on  = feature_q[EFR_ENH_BIT];

    assign mode = (line_ctrl_q == LCR_FEATURE) ? URA_MODE_FEATURE :
                  line_ctrl_q[LCR_DIV_BIT]     ? URA_MODE_DIVISOR :
                                                 URA_MODE_NORMAL;

    // any other value with bit 7 set opens the divisor latch as well
    always_comb begin
        case (mode)
            URA_MODE_NORMAL: begin
                feat_map = 1'b0;
                div_map  = 1'b0;
            end
            URA_MODE_DIVISOR: begin
                feat_map = 1'b0;
                div_map  = 1'b1;
            end
            URA_MODE_FEATURE: begin
                feat_map = 1'b1;
                div_map  = 1'b1;
            end
            default: begin
                feat_map = 1'b0;
                div_map  = 1'b0;
            end
        endcase
    end

    wire dl_addr  = (addr_in == OFS_DIV_LOW) | (addr_in == OFS_DIV_HIGH);
    assign norm_map = ~feat_map & ~(div_map & dl_addr);

    wire ext_en   = (line_ctrl_q == LCR_PLAIN) & enh_on
                    & modem_ctrl_q[MCR_EXT_BIT];
    wire rdy_en   = modem_ctrl_q[MCR_EXT_BIT]
                    & ~modem_ctrl_q[MCR_RDY_OFF_BIT];

    wire sel_dll  = div_map & (addr_in == OFS_DIV_LOW);
    wire sel_dlm  = div_map & (addr_in == OFS_DIV_HIGH);
    wire sel_efr  = feat_map & (addr_in == OFS_FEATURE);
    wire sel_resume_char_one = feat_map & (addr_in == OFS_RESUME_ONE);
    wire sel_pause_char_one = feat_map & (addr_in == OFS_PAUSE_ONE);
    wire sel_resume_char_two = feat_map & (addr_in == OFS_RESUME_TWO);
    wire sel_pause_char_two = feat_map & (addr_in == OFS_PAUSE_TWO);
    wire sel_lcr  = (addr_in == OFS_LINE_CTRL);
    wire sel_data = norm_map & (addr_in == OFS_DATA);
    wire sel_ier  = norm_map & (addr_in == OFS_INT_ENABLE);
    wire sel_fcr  = norm_map & (addr_in == OFS_FIFO_CTRL);
    wire sel_mcr  = norm_map & (addr_in == OFS_MODEM_CTRL);
    wire sel_lsr  = norm_map & (addr_in == OFS_LINE_STAT);
    wire sel_tcr  = norm_map & ext_en & (addr_in == OFS_FLOW_THR);
    wire sel_msr  = norm_map & ~ext_en & (addr_in == OFS_MODEM_STAT);
    wire sel_tlr  = norm_map & ext_en & (addr_in == OFS_TRIG_LVL);
    wire sel_ffr  = norm_map & rdy_en & (addr_in == OFS_FIFO_RDY);
    wire sel_spr  = norm_map & ~ext_en & (addr_in == OFS_SCRATCH);

    // fifo-ready is read-only, so on a read it shadows trigger levels
    always_comb begin
        rdata_d = RST_BYTE;
        if (sel_lcr)        rdata_d = line_ctrl_q;
        else if (sel_dll)   rdata_d = div_low_q;
        else if (sel_dlm)   rdata_d = div_high_q;
        else if (sel_efr)   rdata_d = feature_q;
        else if (sel_resume_char_one)  rdata_d = resume_one_q;
        else if (sel_resume_char_two)  rdata_d = resume_two_q;
        else if (sel_pause_char_one) rdata_d = pause_one_q;
        else if (sel_pause_char_two) rdata_d = pause_two_q;
        else if (sel_data)  rdata_d = rx_data_in;
        else if (sel_ier)   rdata_d = int_en_q;
        else if (sel_fcr)   rdata_d = int_ident_in;
        else if (sel_mcr)   rdata_d = modem_ctrl_q;
        else if (sel_lsr)   rdata_d = line_status_in;
        else if (sel_tcr)   rdata_d = flow_thr_q;
        else if (sel_msr)   rdata_d = modem_status_in;
        else if (sel_ffr)   rdata_d = fifo_ready_in;
        else if (sel_tlr)   rdata_d = trig_lvl_q;
        else if (sel_spr)   rdata_d = scratch_q;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_low_q  <= RST_BYTE;
            div_high_q <= RST_BYTE;
            feature_q  <= RST_BYTE;
            line_ctrl_q <= RST_BYTE;
        end else if (wr_acc) begin
            if (sel_dll) div_low_q <= wdata_in;
            if (sel_dlm) div_high_q <= wdata_in;
            if (sel_efr) feature_q <= wdata_in;
            if (sel_lcr) line_ctrl_q <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            resume_one_q <= RST_BYTE;
            resume_two_q <= RST_BYTE;
            pause_one_q  <= RST_BYTE;
            pause_two_q  <= RST_BYTE;
        end else if (wr_acc) begin
            if (sel_resume_char_one) resume_one_q <= wdata_in;
            if (sel_pause_char_one) pause_one_q <= wdata_in;
            if (sel_resume_char_two) resume_two_q <= wdata_in;
            if (sel_pause_char_two) pause_two_q <= wdata_in;
        end
    end

    // nibbles are stored raw; level = nibble * 4, no halt > resume check
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flow_thr_q <= RST_BYTE;
            trig_lvl_q <= RST_BYTE;
            scratch_q  <= RST_BYTE;
        end else if (wr_acc) begin
            if (sel_tcr) flow_thr_q <= wdata_in;
            if (sel_tlr) trig_lvl_q <= wdata_in;
            if (sel_spr) scratch_q <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            int_en_q     <= RST_BYTE;
            fifo_ctrl_q  <= RST_BYTE;
            modem_ctrl_q <= RST_BYTE;
        end else if (wr_acc) begin
            if (sel_ier)
                int_en_q <= ura_guard(int_en_q, wdata_in, ENH_IER_MASK, enh_on);
            if (sel_fcr)
                fifo_ctrl_q <= ura_guard(fifo_ctrl_q, wdata_in,
                                         ENH_FCR_MASK, enh_on);
            if (sel_mcr)
                modem_ctrl_q <= ura_guard(modem_ctrl_q, wdata_in,
                                          ENH_MCR_MASK, enh_on);
        end
    end

    // data bus drives for the cycle after a read strobe
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q   <= RST_BYTE;
            oe_n_q    <= 1'b1;
            tx_wr_q   <= 1'b0;
            tx_data_q <= RST_BYTE;
            rx_rd_q   <= 1'b0;
        end else begin
            if (rd_acc) rdata_q <= rdata_d;
            oe_n_q  <= ~rd_acc;
            tx_wr_q <= wr_acc & sel_data;
            if (wr_acc & sel_data) tx_data_q <= wdata_in;
            rx_rd_q <= rd_acc & sel_data;
        end
    end

    assign rdata_out          = rdata_q;
    assign data_oe_n_out      = oe_n_q;
    assign tx_write_out       = tx_wr_q;
    assign tx_data_out        = tx_data_q;
    assign rx_read_out        = rx_rd_q;
    assign divisor_out        = {div_high_q, div_low_q};
    assign feature_out        = feature_q;
    assign line_control_out   = line_ctrl_q;
    assign modem_control_out  = modem_ctrl_q;
    assign int_enable_out     = int_en_q;
    assign fifo_control_out   = fifo_ctrl_q;
    assign resume_one_out     = resume_one_q;
    assign resume_two_out     = resume_two_q;
    assign pause_one_out      = pause_one_q;
    assign pause_two_out      = pause_two_q;
    assign flow_threshold_out = flow_thr_q;
    assign trigger_levels_out = trig_lvl_q;
    assign prescale_div4_out  = modem_ctrl_q[MCR_PRESC_BIT];

endmodule // ura_regs

`default_nettype wire

// *** bench/ura_regs_monitor.sv ***
// checker for the register access decode; watches the ports of ura_regs
// assumes one host access per cycle, reads answered one cycle later
`timescale 1ns/1ps
`default_nettype none
module ura_regs_monitor
    import ura_pkg::*;
(
    input wire logic       ref_clk_in,
    input wire logic       nrst_in,
    input wire logic       cs_n_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] fifo_ready_in,
    input wire logic [7:0] rdata_out,
    input wire logic       data_oe_n_out,
    input wire logic [7:0] feature_out,
    input wire logic [7:0] line_control_out,
    input wire logic [7:0] modem_control_out,
    input wire logic [7:0] flow_threshold_out,
    input wire logic       prescale_div4_out
);
    wire logic wr_acc = !cs_n_in && wr_in;
    wire logic rd_acc = !cs_n_in && rd_in;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    a_read_drives_bus: assert property (rd_acc |=> !data_oe_n_out)
        else $error("data bus not driven after a read");
    a_line_ctrl_write: assert property (wr_acc && addr_in == OFS_LINE_CTRL
        |=> line_control_out == $past(wdata_in)) else $error("line control lost");
    a_line_ctrl_read: assert property (rd_acc && addr_in == OFS_LINE_CTRL
        |=> rdata_out == $past(line_control_out)) else $error("bad line control");
    a_feature_write: assert property (wr_acc && addr_in == OFS_FEATURE
        && line_control_out == LCR_FEATURE |=> feature_out == $past(wdata_in))
        else $error("feature write lost");
    a_flow_thr_write: assert property (wr_acc && addr_in == OFS_FLOW_THR
        && line_control_out == LCR_PLAIN && feature_out[EFR_ENH_BIT]
        && modem_control_out[MCR_EXT_BIT]
        |=> flow_threshold_out == $past(wdata_in)) else $error("threshold lost");
    a_fifo_rdy_read: assert property (rd_acc && addr_in == OFS_FIFO_RDY
        && line_control_out != LCR_FEATURE && modem_control_out[MCR_EXT_BIT]
        && !modem_control_out[MCR_RDY_OFF_BIT]
        |=> rdata_out == $past(fifo_ready_in)) else $error("bad ready status");
    a_prescale_follow: assert property (prescale_div4_out
        == modem_control_out[MCR_PRESC_BIT]) else $error("prescale mismatch");
    a_modem_protected: assert property (wr_acc && addr_in == OFS_MODEM_CTRL
        && !line_control_out[LCR_DIV_BIT] && !feature_out[EFR_ENH_BIT]
        |=> $stable(modem_control_out[7:5])) else $error("protected bits moved");
endmodule // ura_regs_monitor
bind ura_regs ura_regs_monitor ura_regs_monitor_inst (.*);
`default_nettype wire

// *** bench/ura_regs_tb.sv ***
// self-checking bench for ura_regs walking the host access sequences
// assumes the one-cycle read answer and zero reset values of ura_regs
`timescale 1ns/1ps
`default_nettype none
module ura_regs_tb;
    import ura_pkg::*;
    logic        ref_clk_in = 1'b0, nrst_in = 1'b0, cs_n_in = 1'b1;
    logic        wr_in = 1'b0, rd_in = 1'b0;
    logic [2:0]  addr_in = 3'h0;
    logic [7:0]  wdata_in = 8'h00, rx_data_in = 8'h5E, int_ident_in = 8'hC1;
    logic [7:0]  line_status_in = 8'h60, modem_status_in = 8'hB0;
    logic [7:0]  fifo_ready_in = 8'hA5, got;
    logic [7:0]  rdata_out, tx_data_out, feature_out, line_control_out;
    logic [7:0]  modem_control_out, int_enable_out, fifo_control_out;
    logic [7:0]  resume_one_out, resume_two_out, pause_one_out;
    logic [7:0]  pause_two_out, flow_threshold_out, trigger_levels_out;
    logic [15:0] divisor_out;
    logic        data_oe_n_out, tx_write_out, rx_read_out, prescale_div4_out;
    int          failures = 0;
    int          comparisons = 0;
    ura_regs ura_regs_inst (.*);
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one access; chip select stays low across exactly one rising edge
    task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        cs_n_in = 1'b0;
        wr_in = w;
        rd_in = !w;
        addr_in = a;
        wdata_in = d;
        @(negedge ref_clk_in);
        cs_n_in = 1'b1;
        got = rdata_out;
        if (!w) check(data_oe_n_out, 1'b0);
    endtask
    // host divisor sequence: save, open, write both bytes, restore
    task t_divisor;
        acc(1, OFS_LINE_CTRL, 8'h03);
        acc(0, OFS_LINE_CTRL, 8'h00);
        check(got, 8'h03);
        acc(1, OFS_LINE_CTRL, LCR_DIVISOR);
        acc(1, OFS_DIV_LOW, 8'h34);
        acc(1, OFS_DIV_HIGH, 8'h12);
        acc(0, OFS_DIV_HIGH, 8'h00);
        acc(1, OFS_LINE_CTRL, 8'h03);
        check(divisor_out, 16'h1234);
        check({got, line_control_out}, 16'h1203);
    endtask
    task t_normal;
        acc(0, OFS_LINE_STAT, 8'h00);
        check(got, line_status_in);
        acc(0, OFS_MODEM_STAT, 8'h00);
        check(got, modem_status_in);
        acc(0, OFS_FIFO_CTRL, 8'h00);
        check(got, int_ident_in);
        acc(1, OFS_DATA, 8'h41);
        check({tx_write_out, tx_data_out}, 16'h0141);
        acc(0, OFS_DATA, 8'h00);
        check({rx_read_out, got}, 16'h015E);
        // enhanced functions still off: protected bits must not move
        acc(1, OFS_INT_ENABLE, 8'hFF);
        acc(1, OFS_FIFO_CTRL, 8'hFF);
        check({int_enable_out, fifo_control_out}, 16'h0FCF);
    endtask
    task t_chars;
        acc(1, OFS_LINE_CTRL, LCR_FEATURE);
        acc(1, OFS_FEATURE, 8'h0A);
        acc(1, OFS_PAUSE_ONE, 8'h13);
        acc(1, OFS_RESUME_ONE, 8'h11);
        acc(1, OFS_PAUSE_TWO, 8'h93);
        acc(1, OFS_RESUME_TWO, 8'h91);
        acc(0, OFS_PAUSE_TWO, 8'h00);
        check({got, resume_two_out}, 16'h9391);
        check({pause_one_out, resume_one_out}, 16'h1311);
        check({feature_out, modem_control_out}, 16'h0A00);
    endtask
    // enables closed first: threshold and protected modem bits must hold
    task t_enhanced;
        acc(1, OFS_LINE_CTRL, LCR_PLAIN);
        acc(1, OFS_FLOW_THR, 8'h5A);
        acc(1, OFS_MODEM_CTRL, 8'hE0);
        check(flow_threshold_out, 8'h00);
        check(modem_control_out, 8'h00);
        acc(1, OFS_LINE_CTRL, LCR_FEATURE);
        acc(0, OFS_FEATURE, 8'h00);
        acc(1, OFS_FEATURE, got + 8'h10);
        acc(1, OFS_LINE_CTRL, LCR_PLAIN);
        acc(0, OFS_MODEM_CTRL, 8'h00);
        acc(1, OFS_MODEM_CTRL, (got & 8'hEF) + 8'h40);
        acc(1, OFS_FLOW_THR, 8'h3C);
        acc(1, OFS_TRIG_LVL, 8'h21);
        acc(0, OFS_FIFO_RDY, 8'h00);
        check(got, fifo_ready_in);
        check({flow_threshold_out, trigger_levels_out}, 16'h3C21);
        acc(1, OFS_INT_ENABLE, 8'hF0);
        check(int_enable_out, 8'hF0);
        acc(1, OFS_MODEM_CTRL, 8'hC0);
        check(prescale_div4_out, 1'b1);
        acc(1, OFS_MODEM_CTRL, 8'hC0 & 8'h7F);
        check({prescale_div4_out, modem_control_out}, 16'h0040);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        nrst_in = 1'b1;
        t_divisor;
        t_normal;
        t_chars;
        t_enhanced;
        report_and_stop;
    end
endmodule // ura_regs_tb
`default_nettype wire
